// [hdl/offset_sum.sv]
`timescale 1ns/100ps
`include "opaddr_cfg.svh"

module offset_sum (
  input  wire logic [`WORD_W-1:0] disp_i,
  input  wire logic               disp_byte_i,
  input  wire logic               use_disp_i,
  input  wire logic [`WORD_W-1:0] base_i,
  input  wire logic               use_base_i,
  input  wire logic [`WORD_W-1:0] index_i,
  input  wire logic               use_index_i,
  output logic      [`WORD_W-1:0] offset_o
);

  logic [`WORD_W-1:0] disp_ext;
  logic [`WORD_W-1:0] d_term;
  logic [`WORD_W-1:0] b_term;
  logic [`WORD_W-1:0] i_term;

  // byte displacement sign extended before adding
  assign disp_ext = disp_byte_i ? {{8{disp_i[7]}}, disp_i[7:0]} : disp_i;
  assign d_term   = use_disp_i  ? disp_ext : 16'h0000;
  assign b_term   = use_base_i  ? base_i   : 16'h0000;
  assign i_term   = use_index_i ? index_i  : 16'h0000;
  // carry out of bit 15 is dropped on purpose: offsets wrap in the segment
  assign offset_o = 16'(d_term + b_term + i_term);

endmodule

// [hdl/opaddr_cfg.svh]
`ifndef OPADDR_CFG_SVH
`define OPADDR_CFG_SVH

`define WORD_W        16
`define VEC_W         8
`define VEC_DIV_ERR   8'h00
`define VEC_STEP      8'h01
`define VEC_NMI       8'h02
`define VEC_BRK       8'h03
`define VEC_OVF       8'h04
`define VEC_BOUND     8'h05
`define VEC_BAD_OP    8'h06
`define VEC_NO_EXT    8'h07
`define VEC_EXT_ERR   8'h10
`define VEC_RSV_LO_A  8'h08
`define VEC_RSV_HI_A  8'h0f
`define VEC_RSV_LO_B  8'h11
`define VEC_RSV_HI_B  8'h1f
`define VEC_USER_LO   8'h20
`define CS_RESET      16'hf000
`define SEG_RESET     16'h0000

`endif

// [hdl/opaddr_pkg.sv]
package opaddr_pkg;

  typedef enum logic [1:0] {
    SEG_EXTRA,
    SEG_CODE,
    SEG_STACK,
    SEG_DATA
  } seg_sel_t;

  typedef enum logic [2:0] {
    AM_DIRECT,
    AM_REG_IND,
    AM_BASED,
    AM_INDEXED,
    AM_BASE_IDX,
    AM_BASE_IDX_DISP
  } addr_mode_t;

  typedef enum logic [1:0] {
    REF_FETCH,
    REF_STACK,
    REF_DATA,
    REF_STR_DST
  } ref_kind_t;

  typedef enum logic [1:0] {
    IND_SRC_IDX,
    IND_DST_IDX,
    IND_GEN_BASE,
    IND_FRAME_BASE
  } ind_sel_t;

endpackage

// [hdl/operand_address_generation.sv]
`timescale 1ns/100ps
`include "opaddr_cfg.svh"

// Operation
// - memory addresses are a 16-bit segment selector and 16-bit offset
// - instruction fetch and prefetch always use the code segment
// - stack pushes, pops and frame-base-based references use stack segment
// - other data references use the data segment
// - string destinations use the extra segment
// - an override prefix replaces the implicit segment for the operand
// - offset is the modulo 2^16 sum of present elements
// - byte displacement is sign extended to 16 bits
// - direct mode offset equals the displacement only
// - register indirect offset is one of four pointer registers
// - based mode adds displacement to a base register
// - indexed mode adds displacement to an index register
// - based indexed mode adds base and index, no displacement
// - based indexed with displacement adds all three
// - register operand from general register, immediate from instruction
// - signed byte and word values are two's complement
// - overflow trap raises vector 4, return past instruction
// - divide error vector 0, bad opcode vector 6, return at fault
// - coprocessor op with extension absent raises vector 7 at instruction
// - extension error delivered as vector 16 at coprocessor op
// - vectors 8-15 and 17-31 reserved; 32-255 user
// - segment is contiguous bytes up to 64K, reached by 16-bit offset
// - non-maskable request uses internal vector 2, no acknowledge

module operand_address_generation (
  input  wire logic                    clock_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    req_i,
  input  wire opaddr_pkg::ref_kind_t   ref_kind_i,
  input  wire opaddr_pkg::addr_mode_t  mode_i,
  input  wire logic                    ovr_valid_i,
  input  wire opaddr_pkg::seg_sel_t    ovr_seg_i,
  input  wire logic [15:0]             disp_i,
  input  wire logic                    disp_byte_i,
  input  wire opaddr_pkg::ind_sel_t    ind_sel_i,
  input  wire logic                    base_is_frame_i,
  input  wire logic                    index_is_dest_i,
  input  wire logic [15:0]             src_index_reg_i,
  input  wire logic [15:0]             dest_index_reg_i,
  input  wire logic [15:0]             general_base_reg_i,
  input  wire logic [15:0]             frame_base_reg_i,
  input  wire logic [15:0]             ip_i,
  input  wire logic [15:0]             sp_i,
  input  wire logic [15:0]             code_seg_i,
  input  wire logic [15:0]             stack_seg_i,
  input  wire logic [15:0]             data_segment_reg_i,
  input  wire logic [15:0]             extra_segment_reg_i,
  input  wire logic                    opnd_req_i,
  input  wire logic                    opnd_is_reg_i,
  input  wire logic                    opnd_word_i,
  input  wire logic [15:0]             gen_reg_i,
  input  wire logic [15:0]             imm_i,
  input  wire logic                    ovf_trap_i,
  input  wire logic                    div_err_i,
  input  wire logic                    bad_opcode_i,
  input  wire logic                    cop_instr_i,
  input  wire logic                    ext_present_i,
  input  wire logic                    ext_error_i,
  input  wire logic                    nmi_i,
  input  wire logic [15:0]             instr_addr_i,
  input  wire logic [15:0]             next_addr_i,
  output logic                         addr_valid_o,
  output logic      [15:0]             seg_o,
  output logic      [15:0]             offset_o,
  output opaddr_pkg::seg_sel_t         seg_used_o,
  output logic                         opnd_valid_o,
  output logic      [15:0]             opnd_o,
  output logic                         vec_valid_o,
  output logic      [7:0]              vec_o,
  output logic      [15:0]             ret_addr_o
);

  // ****************************************************
  // segment choice and offset elements
  // ****************************************************
  opaddr_pkg::seg_sel_t seg_pick;
  logic [15:0]          base_val;
  logic [15:0]          index_val;
  logic [15:0]          mem_off;
  logic [15:0]          off_sel;
  logic [15:0]          seg_val;
  logic                 use_disp;
  logic                 use_base;
  logic                 use_index;
  logic                 frame_used;

  assign base_val  = base_is_frame_i ? frame_base_reg_i : general_base_reg_i;
  assign index_val = index_is_dest_i ? dest_index_reg_i : src_index_reg_i;

  always_comb begin
    use_disp   = 1'b0;
    use_base   = 1'b0;
    use_index  = 1'b0;
    frame_used = 1'b0;
    unique case (mode_i)
      opaddr_pkg::AM_DIRECT: begin
        use_disp = 1'b1;
      end
      opaddr_pkg::AM_REG_IND: begin
        // the register is routed through the base lane below
        use_base   = 1'b1;
        frame_used = (ind_sel_i == opaddr_pkg::IND_FRAME_BASE);
      end
      opaddr_pkg::AM_BASED: begin
        use_disp   = 1'b1;
        use_base   = 1'b1;
        frame_used = base_is_frame_i;
      end
      opaddr_pkg::AM_INDEXED: begin
        use_disp  = 1'b1;
        use_index = 1'b1;
      end
      opaddr_pkg::AM_BASE_IDX: begin
        use_base   = 1'b1;
        use_index  = 1'b1;
        frame_used = base_is_frame_i;
      end
      opaddr_pkg::AM_BASE_IDX_DISP: begin
        use_disp   = 1'b1;
        use_base   = 1'b1;
        use_index  = 1'b1;
        frame_used = base_is_frame_i;
      end
      default: begin
        use_disp = 1'b1;
      end
    endcase
  end

  logic [15:0] base_lane;

  always_comb begin
    base_lane = base_val;
    if (mode_i == opaddr_pkg::AM_REG_IND) begin
      unique case (ind_sel_i)
        opaddr_pkg::IND_SRC_IDX:    base_lane = src_index_reg_i;
        opaddr_pkg::IND_DST_IDX:    base_lane = dest_index_reg_i;
        opaddr_pkg::IND_GEN_BASE:   base_lane = general_base_reg_i;
        opaddr_pkg::IND_FRAME_BASE: base_lane = frame_base_reg_i;
      endcase
    end
  end

  seg_select seg_select_i (
    .ref_kind_i        (ref_kind_i),
    .frame_base_used_i (frame_used),
    .ovr_valid_i       (ovr_valid_i),
    .ovr_seg_i         (ovr_seg_i),
    .seg_o             (seg_pick)
  );

  offset_sum offset_sum_i (
    .disp_i      (disp_i),
    .disp_byte_i (disp_byte_i),
    .use_disp_i  (use_disp),
    .base_i      (base_lane),
    .use_base_i  (use_base),
    .index_i     (index_val),
    .use_index_i (use_index),
    .offset_o    (mem_off)
  );

  // fetch and stack traffic take their offsets from pointers, not operands
  always_comb begin
    unique case (ref_kind_i)
      opaddr_pkg::REF_FETCH: off_sel = ip_i;
      opaddr_pkg::REF_STACK: off_sel = sp_i;
      default:               off_sel = mem_off;
    endcase
  end

  always_comb begin
    unique case (seg_pick)
      opaddr_pkg::SEG_CODE:  seg_val = code_seg_i;
      opaddr_pkg::SEG_STACK: seg_val = stack_seg_i;
      opaddr_pkg::SEG_DATA:  seg_val = data_segment_reg_i;
      opaddr_pkg::SEG_EXTRA: seg_val = extra_segment_reg_i;
    endcase
  end

  // ****************************************************
  // registered address output
  // ****************************************************
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_valid_o <= 1'b0;
      seg_o        <= `CS_RESET;
      offset_o     <= 16'h0000;
      seg_used_o   <= opaddr_pkg::SEG_CODE;
    end else begin
      addr_valid_o <= req_i;
      if (req_i) begin
        seg_o      <= seg_val;
        offset_o   <= off_sel;
        seg_used_o <= seg_pick;
      end
    end
  end

  // ****************************************************
  // register and immediate operands
  // ****************************************************
  logic [15:0] opnd_src;

  // byte operands sign extended so downstream sees two's complement words
  always_comb begin
    opnd_src = opnd_is_reg_i ? gen_reg_i : imm_i;
    if (!opnd_word_i) begin
      opnd_src = {{8{opnd_src[7]}}, opnd_src[7:0]};
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opnd_valid_o <= 1'b0;
      opnd_o       <= 16'h0000;
    end else begin
      opnd_valid_o <= opnd_req_i;
      if (opnd_req_i) begin
        opnd_o <= opnd_src;
      end
    end
  end

  // ****************************************************
  // exception vectors
  // ****************************************************
  logic       vec_hit;
  logic [7:0] vec_d;
  logic [15:0] ret_d;

  // exceptions outrank the non-maskable request; reserved codes never issue
  always_comb begin
    vec_hit = 1'b1;
    vec_d   = `VEC_NMI;
    ret_d   = next_addr_i;
    if (div_err_i) begin
      vec_d = `VEC_DIV_ERR;
      ret_d = instr_addr_i;
    end else if (bad_opcode_i) begin
      vec_d = `VEC_BAD_OP;
      ret_d = instr_addr_i;
    end else if (cop_instr_i && !ext_present_i) begin
      vec_d = `VEC_NO_EXT;
      ret_d = instr_addr_i;
    end else if (cop_instr_i && ext_error_i) begin
      vec_d = `VEC_EXT_ERR;
      ret_d = instr_addr_i;
    end else if (ovf_trap_i) begin
      vec_d = `VEC_OVF;
      ret_d = next_addr_i;
    end else if (nmi_i) begin
      vec_d = `VEC_NMI;
      ret_d = next_addr_i;
    end else begin
      vec_hit = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vec_valid_o <= 1'b0;
      vec_o       <= 8'h00;
      ret_addr_o  <= 16'h0000;
    end else begin
      vec_valid_o <= vec_hit;
      if (vec_hit) begin
        vec_o      <= vec_d;
        ret_addr_o <= ret_d;
      end
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  AST_FETCH_CODE: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_FETCH |=>
    seg_used_o == opaddr_pkg::SEG_CODE && offset_o == $past(ip_i))
    else $error("fetch not on code segment");

  AST_FRAME_STACK: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_DATA && !ovr_valid_i &&
    mode_i == opaddr_pkg::AM_BASED && base_is_frame_i |=>
    seg_used_o == opaddr_pkg::SEG_STACK)
    else $error("frame base not on stack segment");

  AST_DATA_SEG: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_DATA && !ovr_valid_i &&
    mode_i == opaddr_pkg::AM_INDEXED |=> seg_o == $past(data_segment_reg_i))
    else $error("data reference not on data segment");

  AST_STR_DST: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_STR_DST |=>
    seg_o == $past(extra_segment_reg_i))
    else $error("string destination not on extra segment");

  AST_OVERRIDE: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_DATA && ovr_valid_i |=>
    seg_used_o == $past(ovr_seg_i))
    else $error("override ignored");

  AST_DIRECT: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_DATA &&
    mode_i == opaddr_pkg::AM_DIRECT && !disp_byte_i |=>
    offset_o == $past(disp_i))
    else $error("direct offset wrong");

  AST_FULL_SUM: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    req_i && ref_kind_i == opaddr_pkg::REF_DATA && disp_byte_i &&
    mode_i == opaddr_pkg::AM_BASE_IDX_DISP |=>
    offset_o == 16'($past(base_val) + $past(index_val) +
                    {{8{$past(disp_i[7])}}, $past(disp_i[7:0])}))
    else $error("based indexed offset wrong");

  AST_DIV_VEC: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    div_err_i |=> vec_valid_o && vec_o == 8'h00 &&
    ret_addr_o == $past(instr_addr_i))
    else $error("divide error vector wrong");

  AST_OVF_VEC: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    ovf_trap_i && !div_err_i && !bad_opcode_i && !cop_instr_i |=>
    vec_o == 8'h04 && ret_addr_o == $past(next_addr_i))
    else $error("overflow trap vector wrong");

  AST_NO_EXT: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    cop_instr_i && !ext_present_i && !div_err_i && !bad_opcode_i |=>
    vec_o == 8'h07)
    else $error("extension absent vector wrong");

  AST_RSV: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    vec_valid_o |-> !(vec_o inside {[8'h08:8'h0f], [8'h11:8'h1f]}))
    else $error("reserved vector issued");

  AST_NMI: assert property (@(posedge clock_i)
    disable iff (!arst_n_i)
    nmi_i && !div_err_i && !bad_opcode_i && !cop_instr_i && !ovf_trap_i
    |=> vec_valid_o && vec_o == 8'h02)
    else $error("nmi vector wrong");

  COV_OVERRIDE: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    req_i && ovr_valid_i && ref_kind_i == opaddr_pkg::REF_DATA);
  COV_WRAP: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    req_i && mode_i == opaddr_pkg::AM_BASE_IDX_DISP &&
    (17'(base_val) + 17'(index_val)) > 17'h0ffff);
  COV_EXT_ERR: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    vec_valid_o && vec_o == 8'h10);

endmodule

// [hdl/seg_select.sv]
`timescale 1ns/100ps
`include "opaddr_cfg.svh"

module seg_select (
  input  wire opaddr_pkg::ref_kind_t ref_kind_i,
  input  wire logic                  frame_base_used_i,
  input  wire logic                  ovr_valid_i,
  input  wire opaddr_pkg::seg_sel_t  ovr_seg_i,
  output opaddr_pkg::seg_sel_t       seg_o
);

  always_comb begin
    unique case (ref_kind_i)
      opaddr_pkg::REF_FETCH:   seg_o = opaddr_pkg::SEG_CODE;
      opaddr_pkg::REF_STACK:   seg_o = opaddr_pkg::SEG_STACK;
      opaddr_pkg::REF_STR_DST: seg_o = opaddr_pkg::SEG_EXTRA;
      opaddr_pkg::REF_DATA: begin
        if (ovr_valid_i) begin
          seg_o = ovr_seg_i;
        end else if (frame_base_used_i) begin
          seg_o = opaddr_pkg::SEG_STACK;
        end else begin
          seg_o = opaddr_pkg::SEG_DATA;
        end
      end
    endcase
  end

endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps

module tb_top;
  // ****************************************************************
  // short names for the decoder encodings
  // ****************************************************************
  localparam opaddr_pkg::ref_kind_t FE = opaddr_pkg::REF_FETCH,
    ST = opaddr_pkg::REF_STACK, DA = opaddr_pkg::REF_DATA,
    SD = opaddr_pkg::REF_STR_DST;
  localparam opaddr_pkg::addr_mode_t MD = opaddr_pkg::AM_DIRECT,
    MR = opaddr_pkg::AM_REG_IND, MB = opaddr_pkg::AM_BASED,
    MX = opaddr_pkg::AM_INDEXED, MBX = opaddr_pkg::AM_BASE_IDX,
    MBD = opaddr_pkg::AM_BASE_IDX_DISP;
  localparam opaddr_pkg::seg_sel_t GX = opaddr_pkg::SEG_EXTRA,
    GC = opaddr_pkg::SEG_CODE, GS = opaddr_pkg::SEG_STACK,
    GD = opaddr_pkg::SEG_DATA;
  localparam opaddr_pkg::ind_sel_t IS = opaddr_pkg::IND_SRC_IDX,
    ID = opaddr_pkg::IND_DST_IDX, IG = opaddr_pkg::IND_GEN_BASE,
    IFB = opaddr_pkg::IND_FRAME_BASE;

  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                   clock  = 1'b0;
  logic                   arst_n = 1'b0;
  opaddr_pkg::ref_kind_t  kind;
  opaddr_pkg::addr_mode_t mode;
  opaddr_pkg::seg_sel_t   oseg;
  opaddr_pkg::seg_sel_t   seg_used;
  opaddr_pkg::ind_sel_t   ind;
  logic                   req, ovr, db, bfr, idst, oreq, oisreg, oword;
  logic                   ovf, dive, badop, cop, extp, exterr, nmi;
  logic [15:0]            disp, si, di, bx, bp, ip, sp, cs, ss, ds, es;
  logic [15:0]            gr, imm, ia, na, seg, off, opnd, ret;
  logic                   avalid, ovalid, vvalid;
  logic [7:0]             vec;
  int                     failures    = 0;
  int                     checks_done = 0;

  typedef struct packed {
    opaddr_pkg::ref_kind_t  kind;
    opaddr_pkg::addr_mode_t mode;
    logic                   ovr;
    opaddr_pkg::seg_sel_t   oseg;
    logic [15:0]            disp;
    logic                   db;
    opaddr_pkg::ind_sel_t   ind;
    logic                   bf;
    logic                   id;
    opaddr_pkg::seg_sel_t   eseg;
    logic [15:0]            eoff;
  } arow_t;

  typedef struct packed {
    logic [6:0]  ev;
    logic [7:0]  v;
    logic [15:0] r;
  } erow_t;

  // pointers: si 0100, di f800, bx 1234, bp 8000 (wraps chosen on purpose)
  arow_t rows [20] = '{
    '{FE, MD, 1'b1, GX, 16'h0, 1'b0, IS, 1'b0, 1'b0, GC, 16'h5555},
    '{ST, MD, 1'b1, GD, 16'h0, 1'b0, IS, 1'b0, 1'b0, GS, 16'h6666},
    '{DA, MD, 1'b0, GX, 16'h1234, 1'b0, IS, 1'b0, 1'b0, GD, 16'h1234},
    '{DA, MD, 1'b0, GX, 16'h12f0, 1'b1, IS, 1'b0, 1'b0, GD, 16'hfff0},
    '{DA, MR, 1'b0, GX, 16'h7777, 1'b0, IS, 1'b0, 1'b0, GD, 16'h0100},
    '{DA, MR, 1'b0, GX, 16'h0, 1'b0, ID, 1'b0, 1'b0, GD, 16'hf800},
    '{DA, MR, 1'b0, GX, 16'h0, 1'b0, IG, 1'b0, 1'b0, GD, 16'h1234},
    '{DA, MR, 1'b0, GX, 16'h0, 1'b0, IFB, 1'b0, 1'b0, GS, 16'h8000},
    '{DA, MB, 1'b0, GX, 16'h10, 1'b0, IS, 1'b0, 1'b0, GD, 16'h1244},
    '{DA, MB, 1'b0, GX, 16'h80, 1'b1, IS, 1'b1, 1'b0, GS, 16'h7f80},
    '{DA, MX, 1'b0, GX, 16'hff00, 1'b0, IS, 1'b0, 1'b0, GD, 16'h0},
    '{DA, MX, 1'b0, GX, 16'h5, 1'b1, IS, 1'b0, 1'b1, GD, 16'hf805},
    '{DA, MBX, 1'b0, GX, 16'h7777, 1'b0, IS, 1'b0, 1'b1, GD, 16'h0a34},
    '{DA, MBX, 1'b0, GX, 16'h0, 1'b0, IS, 1'b1, 1'b0, GS, 16'h8100},
    '{DA, MBD, 1'b0, GX, 16'h3, 1'b0, IS, 1'b0, 1'b0, GD, 16'h1337},
    '{DA, MBD, 1'b0, GX, 16'hfe, 1'b1, IS, 1'b1, 1'b1, GS, 16'h77fe},
    '{SD, MR, 1'b1, GD, 16'h0, 1'b0, ID, 1'b0, 1'b0, GX, 16'hf800},
    '{DA, MD, 1'b1, GC, 16'h42, 1'b0, IS, 1'b0, 1'b0, GC, 16'h0042},
    '{DA, MB, 1'b1, GX, 16'h0, 1'b0, IS, 1'b1, 1'b0, GX, 16'h8000},
    '{DA, MD, 1'b1, GS, 16'h9, 1'b0, IS, 1'b0, 1'b0, GS, 16'h0009}
  };

  // event bits: divide, bad opcode, coproc op, ext present, ext error,
  // overflow trap, non-maskable
  erow_t evs [8] = '{
    '{7'b1001000, 8'h00, 16'h0a00},
    '{7'b0101000, 8'h06, 16'h0a00},
    '{7'b0010000, 8'h07, 16'h0a00},
    '{7'b0011100, 8'h10, 16'h0a00},
    '{7'b0001010, 8'h04, 16'h0a03},
    '{7'b0001001, 8'h02, 16'h0a03},
    '{7'b1001001, 8'h00, 16'h0a00},
    '{7'b0001011, 8'h04, 16'h0a03}
  };

  logic [15:0] oexp [4] = '{16'hff81, 16'h0081, 16'hfff5, 16'h12f5};

  always #4 clock = ~clock;

  // ****************************************************************
  // design under test
  // ****************************************************************
  operand_address_generation operand_address_generation_i (
    .clock_i             (clock),
    .arst_n_i            (arst_n),
    .req_i               (req),
    .ref_kind_i          (kind),
    .mode_i              (mode),
    .ovr_valid_i         (ovr),
    .ovr_seg_i           (oseg),
    .disp_i              (disp),
    .disp_byte_i         (db),
    .ind_sel_i           (ind),
    .base_is_frame_i     (bfr),
    .index_is_dest_i     (idst),
    .src_index_reg_i     (si),
    .dest_index_reg_i    (di),
    .general_base_reg_i  (bx),
    .frame_base_reg_i    (bp),
    .ip_i                (ip),
    .sp_i                (sp),
    .code_seg_i          (cs),
    .stack_seg_i         (ss),
    .data_segment_reg_i  (ds),
    .extra_segment_reg_i (es),
    .opnd_req_i          (oreq),
    .opnd_is_reg_i       (oisreg),
    .opnd_word_i         (oword),
    .gen_reg_i           (gr),
    .imm_i               (imm),
    .ovf_trap_i          (ovf),
    .div_err_i           (dive),
    .bad_opcode_i        (badop),
    .cop_instr_i         (cop),
    .ext_present_i       (extp),
    .ext_error_i         (exterr),
    .nmi_i               (nmi),
    .instr_addr_i        (ia),
    .next_addr_i         (na),
    .addr_valid_o        (avalid),
    .seg_o               (seg),
    .offset_o            (off),
    .seg_used_o          (seg_used),
    .opnd_valid_o        (ovalid),
    .opnd_o              (opnd),
    .vec_valid_o         (vvalid),
    .vec_o               (vec),
    .ret_addr_o          (ret)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] seg_val(opaddr_pkg::seg_sel_t s);
    case (s)
      GC: return cs;
      GS: return ss;
      GD: return ds;
      default: return es;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic check_reset();
    check(avalid, 0, "addr valid in reset");
    check(vvalid, 0, "vec valid in reset");
    check(seg, 16'hf000, "seg in reset");
    check(seg_used, GC, "seg sel in reset");
    check(off, 0, "offset in reset");
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // the whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clock);
    failures++;
    complete_run();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {req, ovr, db, bfr, idst, oreq, oisreg, oword} = '0;
    {ovf, dive, badop, cop, exterr, nmi} = '0;
    extp = 1'b1;
    kind = FE;
    mode = MD;
    oseg = GX;
    ind  = IS;
    disp = 16'h0;
    si = 16'h0100;
    di = 16'hf800;
    bx = 16'h1234;
    bp = 16'h8000;
    ip = 16'h5555;
    sp = 16'h6666;
    cs = 16'hc000;
    ss = 16'hd000;
    ds = 16'he000;
    es = 16'ha000;
    gr = 16'h12f5;
    imm = 16'h0081;
    ia = 16'h0a00;
    na = 16'h0a03;
    repeat (12) @(negedge clock);
    check_reset();
    check(opnd, 0, "operand in reset");
    check(ret, 0, "return in reset");
    arst_n = 1'b1;
    // back to back address requests, one per cycle
    foreach (rows[i]) begin
      kind = rows[i].kind;
      mode = rows[i].mode;
      ovr  = rows[i].ovr;
      oseg = rows[i].oseg;
      disp = rows[i].disp;
      db   = rows[i].db;
      ind  = rows[i].ind;
      bfr  = rows[i].bf;
      idst = rows[i].id;
      req  = 1'b1;
      @(negedge clock);
      check(avalid, 1, "addr valid");
      check(seg_used, rows[i].eseg, "segment select");
      check(seg, seg_val(rows[i].eseg), "segment value");
      check(off, rows[i].eoff, "offset");
    end
    $display("test address table done");
    req  = 1'b0;
    disp = 16'h5a5a;
    @(negedge clock);
    check(avalid, 0, "addr valid drop");
    check(off, 16'h0009, "offset held");
    check(seg_used, GS, "segment held");
    for (int j = 0; j < 4; j++) begin
      {oisreg, oword} = j[1:0];
      oreq = 1'b1;
      @(negedge clock);
      check(ovalid, 1, "operand valid");
      check(opnd, oexp[j], "operand value");
    end
    oreq = 1'b0;
    @(negedge clock);
    check(ovalid, 0, "operand valid drop");
    $display("test operand done");
    foreach (evs[i]) begin
      {dive, badop, cop, extp, exterr, ovf, nmi} = evs[i].ev;
      @(negedge clock);
      check(vvalid, 1, "vector valid");
      check(vec, evs[i].v, "vector number");
      check(ret, evs[i].r, "return address");
      check((vec >= 8'h08 && vec <= 8'h0f) ||
            (vec >= 8'h11 && vec <= 8'h1f), 0, "reserved vector");
    end
    {dive, badop, cop, exterr, ovf, nmi} = '0;
    extp = 1'b1;
    @(negedge clock);
    check(vvalid, 0, "vector valid drop");
    check(vec, 8'h04, "vector held");
    $display("test events done");
    // reset in mid-run while a request is pending
    kind = DA;
    mode = MD;
    ovr  = 1'b0;
    disp = 16'h0077;
    req  = 1'b1;
    @(negedge clock);
    arst_n = 1'b0;
    #1;
    check_reset();
    @(negedge clock);
    arst_n = 1'b1;
    kind = FE;
    @(negedge clock);
    check(seg_used, GC, "fetch after reset");
    check(off, 16'h5555, "fetch offset");
    req = 1'b0;
    $display("test reset done");
    complete_run();
  end
endmodule
